// file: hw/dual_8bit_timer_control.sv
// control and counting for a pair of cascadable 8-bit timers
// assumes: one clock, register port strobes one cycle long
`timescale 1ns/100ps
`include "timer_regs.svh"
module dual_8bit_timer_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic low_freq_clock,
   input wire logic lower_pin,
   input wire logic upper_pin,
   output logic [7:0] rdata,
   output logic lower_ff_out,
   output logic upper_ff_out
);
   timer_tick_if tk ();

   // ----------------------------------------------------------------
   // registers and counters
   // ----------------------------------------------------------------
   logic [7:0] lower_timer_control, next_lower_timer_control;
   logic [7:0] upper_timer_control, next_upper_timer_control;
   logic [7:0] lower_period_reg, next_lower_period_reg;
   logic [7:0] lower_pulse_width_reg, next_lower_pulse_width_reg;
   logic [7:0] upper_period_reg, next_upper_period_reg;
   logic [7:0] upper_pulse_width_reg, next_upper_pulse_width_reg;
   logic [1:0] option, next_option;
   logic [7:0] lower_count, next_lower_count;
   logic [7:0] upper_count, next_upper_count;
   logic lower_ff, next_lower_ff;
   logic upper_ff, next_upper_ff;
   logic [7:0] next_rdata;

   logic [2:0] lower_mode_select, upper_mode_select;
   logic lower_run_control, upper_run_control;
   logic cascade, lower_run, upper_run, lower_carry, upper_step;
   logic lower_match, upper_match;

   // read decode; used only by the read data register below
   function automatic logic [7:0] read_mux(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `OFS_LOWER_CTRL: d = lower_timer_control;
         `OFS_UPPER_CTRL: d = upper_timer_control;
         `OFS_LOWER_PERIOD: d = lower_period_reg;
         `OFS_LOWER_PW: d = lower_pulse_width_reg;
         `OFS_UPPER_PERIOD: d = upper_period_reg;
         `OFS_UPPER_PW: d = upper_pulse_width_reg;
         `OFS_OPTION: d = {6'h00, option};
         `OFS_LOWER_COUNT: d = lower_count;
         `OFS_UPPER_COUNT: d = upper_count;
         default: d = 8'h00; // unmapped reads as zero
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // field decode and mode qualification
   // ----------------------------------------------------------------
   assign lower_mode_select =
      lower_timer_control[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign upper_mode_select =
      upper_timer_control[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign lower_run_control = lower_timer_control[`CTRL_RUN_BIT];
   assign upper_run_control = upper_timer_control[`CTRL_RUN_BIT];
   assign cascade = lower_mode_select ==
      timer_pkg::LOW_CASCADE;
   // reserved lower modes never count; cascade runs from upper run bit
   assign lower_run = cascade ? upper_run_control :
      (lower_run_control & !lower_mode_select[2]);
   assign upper_run = upper_run_control &
      (upper_mode_select != timer_pkg::UP_RESERVED);
   assign lower_match = lower_count == lower_period_reg;
   assign upper_match = upper_count == upper_period_reg;
   // lower carry feeds the upper counter in the 16-bit modes
   assign lower_carry = lower_run & tk.lower_tick &
      (cascade ? (lower_count == 8'hFF) : lower_match);
   assign upper_step = upper_mode_select[2] ? lower_carry :
      tk.upper_tick;

   // prescaler sees the lower select field in cascade too
   assign tk.lower_sel = lower_timer_control[`CTRL_CLK_HI:`CTRL_CLK_LO];
   assign tk.upper_sel = upper_timer_control[`CTRL_CLK_HI:`CTRL_CLK_LO];
   assign tk.divider_source_option = option[`OPT_DIV_BIT];
   assign tk.slow_mode = option[`OPT_SLOW_BIT];
   assign tk.warmup = cascade &&
      upper_mode_select == timer_pkg::UP_WARMUP;

   timer_prescaler u_prescaler (
      .clk(clk),
      .rst(rst),
      .low_freq_clock(low_freq_clock),
      .lower_pin(lower_pin),
      .upper_pin(upper_pin),
      .tk(tk)
   );

   // ----------------------------------------------------------------
   // register writes and read data
   // ----------------------------------------------------------------
   // no write is refused: keeping settings still while running is
   // left to software, which keeps the write path trivial
   always_comb begin
      next_lower_timer_control = lower_timer_control;
      next_upper_timer_control = upper_timer_control;
      next_lower_period_reg = lower_period_reg;
      next_lower_pulse_width_reg = lower_pulse_width_reg;
      next_upper_period_reg = upper_period_reg;
      next_upper_pulse_width_reg = upper_pulse_width_reg;
      next_option = option;
      next_rdata = rd ? read_mux(addr) : 8'h00; // data only after a read
      if (wr) begin
         case (addr)
            `OFS_LOWER_CTRL: next_lower_timer_control = wdata;
            `OFS_UPPER_CTRL: next_upper_timer_control = wdata;
            `OFS_LOWER_PERIOD: next_lower_period_reg = wdata;
            `OFS_LOWER_PW: next_lower_pulse_width_reg = wdata;
            `OFS_UPPER_PERIOD: next_upper_period_reg = wdata;
            `OFS_UPPER_PW: next_upper_pulse_width_reg = wdata;
            `OFS_OPTION: next_option = wdata[1:0];
            default: next_option = option;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lower_timer_control <= `CTRL_RESET;
         upper_timer_control <= `CTRL_RESET;
         lower_period_reg <= `REG_RESET;
         lower_pulse_width_reg <= `REG_RESET;
         upper_period_reg <= `REG_RESET;
         upper_pulse_width_reg <= `REG_RESET;
         option <= 2'h0;
         rdata <= 8'h00;
      end else begin
         lower_timer_control <= next_lower_timer_control;
         upper_timer_control <= next_upper_timer_control;
         lower_period_reg <= next_lower_period_reg;
         lower_pulse_width_reg <= next_lower_pulse_width_reg;
         upper_period_reg <= next_upper_period_reg;
         upper_pulse_width_reg <= next_upper_pulse_width_reg;
         option <= next_option;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // counters and timer flip-flops
   // ----------------------------------------------------------------
   always_comb begin
      next_lower_count = lower_count;
      next_upper_count = upper_count;
      next_lower_ff = lower_ff;
      next_upper_ff = upper_ff;
      // lower unit
      if (!lower_run) begin
         next_lower_count = 8'h00;
      end else if (tk.lower_tick) begin
         case (timer_pkg::lower_mode_t'(lower_mode_select))
            timer_pkg::LOW_TIMER, timer_pkg::LOW_DIVIDER: begin
               next_lower_count = lower_match ? 8'h00 :
                  lower_count + 8'h01;
               if (lower_match && lower_mode_select[0]) begin
                  next_lower_ff = !lower_ff;
               end
            end
            timer_pkg::LOW_PWM: begin
               next_lower_count = lower_count + 8'h01;
               if (lower_count == lower_pulse_width_reg ||
                  lower_count == 8'hFF) begin
                  next_lower_ff = !lower_ff;
               end
            end
            default: next_lower_count = lower_count + 8'h01;
         endcase
      end
      // upper unit, stepped by its own tick or the lower carry
      if (!upper_run) begin
         next_upper_count = 8'h00;
      end else if (upper_step) begin
         if (upper_mode_select[1:0] == 2'h2) begin
            next_upper_count = upper_count + 8'h01;
            if (upper_count == upper_pulse_width_reg ||
               upper_count == 8'hFF) begin
               next_upper_ff = !upper_ff;
            end
         end else begin
            next_upper_count = upper_match ? 8'h00 : upper_count + 8'h01;
            if (upper_match && upper_mode_select != timer_pkg::UP_TIMER) begin
               next_upper_ff = !upper_ff;
            end
         end
      end
      // a control write presets the flip-flop; cascade uses the upper
      if (wr && addr == `OFS_LOWER_CTRL && !cascade) begin
         next_lower_ff = wdata[`CTRL_PRESET_BIT];
      end
      if (wr && addr == `OFS_UPPER_CTRL) begin
         next_upper_ff = wdata[`CTRL_PRESET_BIT];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lower_count <= 8'h00;
         upper_count <= 8'h00;
         lower_ff <= 1'b0;
         upper_ff <= 1'b0;
         lower_ff_out <= 1'b0;
         upper_ff_out <= 1'b0;
      end else begin
         lower_count <= next_lower_count;
         upper_count <= next_upper_count;
         lower_ff <= next_lower_ff;
         upper_ff <= next_upper_ff;
         lower_ff_out <= next_lower_ff;
         upper_ff_out <= next_upper_ff;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence lower_counts_up;
      lower_run && tk.lower_tick && !wr &&
         lower_mode_select == 3'h0 && !lower_match;
   endsequence

   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OFS_LOWER_CTRL |=> lower_timer_control == $past(wdata))
      else $error("lower control write not stored");
   a_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
      rd && addr == `OFS_LOWER_CTRL && !wr
      |=> rdata == $past(lower_timer_control))
      else $error("lower control read back wrong");
   a_preset_value: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OFS_UPPER_CTRL ##1 1'b1
      |-> upper_ff_out == $past(wdata[7], 1))
      else $error("upper flip-flop not preset from written bit");
   a_stop_clears: assert property (@(posedge clk) disable iff (rst)
      !lower_run |=> lower_count == 8'h00)
      else $error("stopped lower counter not cleared");
   a_reserved_still: assert property (@(posedge clk) disable iff (rst)
      lower_run_control && lower_mode_select[2] |=> lower_count == 8'h00)
      else $error("reserved lower mode counts");
   a_cascade_run: assert property (@(posedge clk) disable iff (rst)
      cascade && !upper_run_control |=> lower_count == 8'h00)
      else $error("cascade lower runs without upper run bit");
   a_upper_chain: assert property (@(posedge clk) disable iff (rst)
      upper_run && upper_mode_select[2] && !lower_carry
      |=> upper_count == $past(upper_count))
      else $error("upper counter moved without lower carry");
   a_count_step: assert property (@(posedge clk) disable iff (rst)
      lower_counts_up |=> lower_count == $past(lower_count) + 8'h01)
      else $error("lower timer did not step by one");
   a_match_wrap: assert property (@(posedge clk) disable iff (rst)
      lower_run && tk.lower_tick && lower_mode_select == 3'h0 &&
      lower_match ##1 1'b1 |-> lower_count == 8'h00)
      else $error("lower timer not cleared on period match");

   // divider mode: a period match flips the flip-flop; a write could
   // preset it in the same cycle, so writes are left out here
   sequence lower_divider_match;
      lower_run && tk.lower_tick && !wr &&
         lower_mode_select == 3'h1 && lower_match;
   endsequence

   a_divider_toggle: assert property (@(posedge clk) disable iff (rst)
      lower_divider_match |=> lower_ff_out != $past(lower_ff_out))
      else $error("divider mode match did not toggle the flip-flop");
   // a lower control write presets its own flip-flop outside cascade
   a_lower_preset: assert property (@(posedge clk) disable iff (rst)
      wr && addr == `OFS_LOWER_CTRL && !cascade
      |=> lower_ff_out == $past(wdata[`CTRL_PRESET_BIT]))
      else $error("lower flip-flop not preset from written bit");
   // in cascade the lower flip-flop is neither preset nor toggled
   a_cascade_keep: assert property (@(posedge clk) disable iff (rst)
      cascade |=> lower_ff_out == $past(lower_ff_out))
      else $error("lower flip-flop moved in cascade");
   // reserved upper mode never lets the counter leave zero
   a_upper_hold: assert property (@(posedge clk) disable iff (rst)
      upper_run_control && upper_mode_select == 3'h3 |=> upper_count == 8'h00)
      else $error("reserved upper mode counts");
   // read data stand only in the cycle after the strobe
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      !rd |=> rdata == 8'h00)
      else $error("read data stand beyond the read cycle");
   // the undivided clock only survives slow mode for warm-up counting
   a_warmup_only: assert property (@(posedge clk) disable iff (rst)
      tk.slow_mode && tk.lower_sel == 3'h6 |-> tk.lower_tick == tk.warmup)
      else $error("undivided clock in slow mode outside warm-up");
endmodule // dual_8bit_timer_control

// file: hw/timer_regs.svh
// register offsets, field positions, reset values and divider figures
// assumes: included by bare name by every file that decodes registers
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define OFS_LOWER_CTRL 8'h18
`define OFS_UPPER_CTRL 8'h19
`define OFS_LOWER_PERIOD 8'h1A
`define OFS_LOWER_PW 8'h1B
`define OFS_UPPER_PERIOD 8'h1C
`define OFS_UPPER_PW 8'h1D
`define OFS_OPTION 8'h1E
`define OFS_LOWER_COUNT 8'h20
`define OFS_UPPER_COUNT 8'h21

// ----------------------------------------------------------------
// control and option register fields and reset values
// ----------------------------------------------------------------
`define CTRL_PRESET_BIT 7
`define CTRL_CLK_HI 6
`define CTRL_CLK_LO 4
`define CTRL_RUN_BIT 3
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 0
`define OPT_DIV_BIT 0
`define OPT_SLOW_BIT 1
`define CTRL_RESET 8'h00
`define REG_RESET 8'h00

// ----------------------------------------------------------------
// prescaler: divider width and the tap exponents
// ----------------------------------------------------------------
`define DIV_WIDTH 11
`define DIV_EXP_A 11
`define DIV_EXP_B 7
`define DIV_EXP_C 5
`define DIV_EXP_D 3
`define LOW_DIV_EXP 3

`endif

// file: hw/timer_pkg.sv
// types shared by the timer control and its prescaler
// assumes: nothing beyond a SystemVerilog compiler
package timer_pkg;

   // lower unit operating modes, codes 1xx are reserved
   typedef enum logic [2:0] {
      LOW_TIMER = 3'h0,
      LOW_DIVIDER = 3'h1,
      LOW_PWM = 3'h2,
      LOW_CASCADE = 3'h3
   } lower_mode_t;

   // upper unit operating modes, code 3 is reserved
   typedef enum logic [2:0] {
      UP_TIMER = 3'h0,
      UP_DIVIDER = 3'h1,
      UP_PWM = 3'h2,
      UP_RESERVED = 3'h3,
      UP_TIMER16 = 3'h4,
      UP_WARMUP = 3'h5,
      UP_PWM16 = 3'h6,
      UP_PULSE16 = 3'h7
   } upper_mode_t;

   // clock select codes
   typedef enum logic [2:0] {
      CK_DIV11 = 3'h0,
      CK_DIV7 = 3'h1,
      CK_DIV5 = 3'h2,
      CK_DIV3 = 3'h3,
      CK_LOW = 3'h4,
      CK_HALF = 3'h5,
      CK_HIGH = 3'h6,
      CK_PIN = 3'h7
   } clk_sel_t;

endpackage

// file: hw/timer_tick_if.sv
// clock selections going to the prescaler and ticks coming back
// assumes: both ends share clk
`timescale 1ns/100ps
interface timer_tick_if;
   logic [2:0] lower_sel;
   logic [2:0] upper_sel;
   logic divider_source_option;
   logic slow_mode;
   logic warmup;
   logic lower_tick;
   logic upper_tick;
   modport control (output lower_sel, upper_sel, divider_source_option,
      slow_mode, warmup, input lower_tick, upper_tick);
   modport prescaler (input lower_sel, upper_sel, divider_source_option,
      slow_mode, warmup, output lower_tick, upper_tick);
endinterface

// file: hw/timer_prescaler.sv
// source clock divider and per-unit clock select
// assumes: low_freq_clock and pins are synchronous to clk
`timescale 1ns/100ps
`include "timer_regs.svh"
module timer_prescaler (
   input wire logic clk,
   input wire logic rst,
   input wire logic low_freq_clock,
   input wire logic lower_pin,
   input wire logic upper_pin,
   timer_tick_if.prescaler tk
);
   logic [`DIV_WIDTH-1:0] div, next_div;
   logic [`LOW_DIV_EXP-1:0] low_div, next_low_div;
   logic [1:0] pin_prev, next_pin_prev;
   logic [7:0] taps_fast;
   logic lower_pin_edge, upper_pin_edge, low_div_tick;

   // one tick enable per select code; the high clock itself is clk
   function automatic logic pick(input logic [2:0] sel, input logic pin_e,
      input logic dv, input logic slow, input logic warm);
      logic t;
      t = 1'b0;
      case (timer_pkg::clk_sel_t'(sel))
         timer_pkg::CK_DIV11: t = (dv | slow) ? low_div_tick : taps_fast[0];
         timer_pkg::CK_LOW: t = low_freq_clock;
         timer_pkg::CK_PIN: t = pin_e;
         timer_pkg::CK_HIGH: t = !slow | warm;
         default: t = !slow & taps_fast[sel];
      endcase
      return t;
   endfunction

   // ----------------------------------------------------------------
   // divider taps
   // ----------------------------------------------------------------
   assign low_div_tick = low_freq_clock & (&low_div);
   assign lower_pin_edge = lower_pin & !pin_prev[0];
   assign upper_pin_edge = upper_pin & !pin_prev[1];
   always_comb begin
      taps_fast = 8'h00;
      taps_fast[0] = &div[`DIV_EXP_A-1:0];
      taps_fast[1] = &div[`DIV_EXP_B-1:0];
      taps_fast[2] = &div[`DIV_EXP_C-1:0];
      taps_fast[3] = &div[`DIV_EXP_D-1:0];
      taps_fast[5] = div[0];
   end

   // free running counters and pin edge history
   always_comb begin
      next_div = div + 1'b1;
      next_low_div = low_freq_clock ? low_div + 1'b1 : low_div;
      next_pin_prev = {upper_pin, lower_pin};
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div <= '0;
         low_div <= '0;
         pin_prev <= 2'h0;
      end else begin
         div <= next_div;
         low_div <= next_low_div;
         pin_prev <= next_pin_prev;
      end
   end

   assign tk.lower_tick = pick(tk.lower_sel, lower_pin_edge,
      tk.divider_source_option, tk.slow_mode, tk.warmup);
   assign tk.upper_tick = pick(tk.upper_sel, upper_pin_edge,
      tk.divider_source_option, tk.slow_mode, 1'b0);

   a_slow_gate: assert property (@(posedge clk) disable iff (rst)
      tk.slow_mode && tk.lower_sel inside {3'h1, 3'h2, 3'h3, 3'h5}
      |-> !tk.lower_tick) else $error("divided high clock ticks in slow");
   a_high_select: assert property (@(posedge clk) disable iff (rst)
      !tk.slow_mode && tk.lower_sel == 3'h6 |-> tk.lower_tick)
      else $error("high clock select does not tick every cycle");
endmodule // timer_prescaler

// file: sim/testbench.sv
// register-level bench for the dual 8-bit timer control block
// assumes: plain register port, read data one cycle after rd, 40 MHz clk
`timescale 1ns/100ps
`include "timer_regs.svh"
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic low_freq_clock = 1'b0;
   logic lower_pin = 1'b0;
   logic upper_pin = 1'b0;
   logic [7:0] rdata;
   logic lower_ff_out;
   logic upper_ff_out;
   int n_fail = 0;
   int tests_run = 0;
   logic [7:0] ofs [9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
      8'h1E, 8'h20, 8'h21};
   logic [7:0] val [7] = '{8'h72, 8'h51, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h03};
   // one row: control, option, source, pulses, expected count
   logic [7:0] tab [7][5] = '{
      '{8'h78, 8'h00, 8'h00, 8'h05, 8'h05},
      '{8'h48, 8'h00, 8'h02, 8'h06, 8'h06},
      '{8'h08, 8'h01, 8'h02, 8'h10, 8'h02},
      '{8'h7C, 8'h00, 8'h00, 8'h05, 8'h00},
      '{8'h48, 8'h02, 8'h02, 8'h03, 8'h03},
      '{8'h58, 8'h02, 8'h02, 8'h03, 8'h00},
      '{8'h68, 8'h02, 8'h02, 8'h03, 8'h00}};

   // ----------------------------------------------------------------
   // clock, reset and design
   // ----------------------------------------------------------------
   initial begin
      forever #12.5 clk = ~clk;
   end

   dual_8bit_timer_control dut (
      .clk(clk),
      .rst(rst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .low_freq_clock(low_freq_clock),
      .lower_pin(lower_pin),
      .upper_pin(upper_pin),
      .rdata(rdata),
      .lower_ff_out(lower_ff_out),
      .upper_ff_out(upper_ff_out)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // compare one value, count it, report a mismatch at once
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // step off the edge so a following compare sees the new state
      #1;
   endtask

   // read data stand only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // one-cycle pulses with a gap, so every pulse is a fresh rising edge
   task automatic pulse(input logic [7:0] src, input int n);
      repeat (n) begin
         @(posedge clk);
         case (src)
            8'h00: lower_pin <= 1'b1;
            8'h01: upper_pin <= 1'b1;
            default: low_freq_clock <= 1'b1;
         endcase
         @(posedge clk);
         lower_pin <= 1'b0;
         upper_pin <= 1'b0;
         low_freq_clock <= 1'b0;
      end
      // pin edges count in the cycle the pin rises; the trailing idle cycles only pad before the next access
      repeat (4) @(posedge clk);
   endtask

   task automatic conclude;
      $display("compares %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog: the run needs about 900 cycles
   // ----------------------------------------------------------------
   initial begin
      #(25 * 20000);
      n_fail++;
      conclude();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // reset values of every register and both flip-flops
      foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
      check({7'h00, lower_ff_out}, 8'h00);
      check({7'h00, upper_ff_out}, 8'h00);
      $display("test reset done");
      // write then read back; a write to a hole leaves nothing behind
      foreach (val[i]) wr_reg(ofs[i], val[i]);
      foreach (val[i]) rd_chk(ofs[i], val[i]);
      wr_reg(8'h30, 8'hFF);
      rd_chk(8'h30, 8'h00);
      wr_reg(`OFS_OPTION, 8'h00);
      wr_reg(`OFS_UPPER_CTRL, 8'h00);
      wr_reg(`OFS_LOWER_CTRL, 8'h00);
      $display("test readback done");
      // flip-flop preset set and clear on both units
      wr_reg(`OFS_LOWER_CTRL, 8'h80);
      check({7'h00, lower_ff_out}, 8'h01);
      wr_reg(`OFS_LOWER_CTRL, 8'h00);
      check({7'h00, lower_ff_out}, 8'h00);
      wr_reg(`OFS_UPPER_CTRL, 8'h80);
      check({7'h00, upper_ff_out}, 8'h01);
      wr_reg(`OFS_UPPER_CTRL, 8'h00);
      check({7'h00, upper_ff_out}, 8'h00);
      $display("test preset done");
      // source selects, reserved mode and slow-mode limits; stop clears
      foreach (tab[i]) begin
         wr_reg(`OFS_LOWER_PERIOD, 8'hFF);
         wr_reg(`OFS_OPTION, tab[i][1]);
         wr_reg(`OFS_LOWER_CTRL, tab[i][0]);
         pulse(tab[i][2], int'(tab[i][3]));
         rd_chk(`OFS_LOWER_COUNT, tab[i][4]);
         wr_reg(`OFS_LOWER_CTRL, tab[i][0] & 8'hF7);
         rd_chk(`OFS_LOWER_COUNT, 8'h00);
      end
      wr_reg(`OFS_OPTION, 8'h00);
      $display("test sources done");
      // divider output: third pin edge meets period 2, wraps and toggles
      wr_reg(`OFS_LOWER_PERIOD, 8'h02);
      wr_reg(`OFS_LOWER_CTRL, 8'h79);
      pulse(8'h00, 3);
      check({7'h00, lower_ff_out}, 8'h01);
      rd_chk(`OFS_LOWER_COUNT, 8'h00);
      wr_reg(`OFS_LOWER_CTRL, 8'h71);
      // modulation: the flip-flop flips where the count meets width 1
      wr_reg(`OFS_LOWER_PW, 8'h01);
      wr_reg(`OFS_LOWER_CTRL, 8'h7A);
      pulse(8'h00, 2);
      check({7'h00, lower_ff_out}, 8'h01);
      rd_chk(`OFS_LOWER_COUNT, 8'h02);
      wr_reg(`OFS_LOWER_CTRL, 8'h72);
      check({7'h00, lower_ff_out}, 8'h00);
      $display("test modes done");
      // cascade: lower run bit stays 0, the upper unit starts the pair
      wr_reg(`OFS_UPPER_PERIOD, 8'hFF);
      wr_reg(`OFS_LOWER_CTRL, 8'h73);
      wr_reg(`OFS_UPPER_CTRL, 8'h8C);
      check({7'h00, upper_ff_out}, 8'h01);
      pulse(8'h00, 257);
      rd_chk(`OFS_LOWER_COUNT, 8'h01);
      rd_chk(`OFS_UPPER_COUNT, 8'h01);
      // the upper pin must not step the upper half in 16-bit mode
      pulse(8'h01, 3);
      rd_chk(`OFS_UPPER_COUNT, 8'h01);
      wr_reg(`OFS_UPPER_CTRL, 8'h84);
      rd_chk(`OFS_UPPER_COUNT, 8'h00);
      rd_chk(`OFS_LOWER_COUNT, 8'h00);
      check({7'h00, upper_ff_out}, 8'h01);
      // slow mode: the undivided clock steps the pair only for warm-up
      wr_reg(`OFS_OPTION, 8'h02);
      wr_reg(`OFS_LOWER_CTRL, 8'h63);
      wr_reg(`OFS_UPPER_CTRL, 8'h0D);
      rd_chk(`OFS_LOWER_COUNT, 8'h01);
      wr_reg(`OFS_UPPER_CTRL, 8'h05);
      rd_chk(`OFS_LOWER_COUNT, 8'h00);
      wr_reg(`OFS_OPTION, 8'h00);
      $display("test cascade done");
      // upper unit on its own: 8-bit timer counts, code 011 holds still
      wr_reg(`OFS_LOWER_CTRL, 8'h00);
      wr_reg(`OFS_UPPER_CTRL, 8'h78);
      pulse(8'h01, 4);
      rd_chk(`OFS_UPPER_COUNT, 8'h04);
      wr_reg(`OFS_UPPER_CTRL, 8'h70);
      wr_reg(`OFS_UPPER_CTRL, 8'h7B);
      pulse(8'h01, 4);
      rd_chk(`OFS_UPPER_COUNT, 8'h00);
      $display("test upper done");
      conclude();
   end
endmodule // testbench
